// >>> core_model.sv
// Behavioural processor core: an APB master issuing word transfers.
// Assumes the shared clock and a timeout task in tb_top.
`timescale 1ns/100ps
`default_nettype none
module core_model (
  input  wire logic        clk_i,
  output var  logic        psel_o,
  output var  logic        penable_o,
  output var  logic        pwrite_o,
  output var  logic [11:0] paddr_o,
  output var  logic [31:0] pwdata_o,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i
);
  logic last_err;
  // Idle bus from time zero
  initial
  begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h0;
    pwdata_o = 32'h0;
  end
  // One transfer; starting on a fresh edge keeps back-to-back calls clean
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    // Hold everything until pready is sampled high
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (pready_i !== 1'b1 && n < 16);
    if (pready_i !== 1'b1)
      tb_top.timeout();
    q = prdata_i;
    last_err = pslverr_i;
    // Released lines flip so a stale value cannot pass for a fresh one
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    paddr_o <= ~a;
    pwdata_o <= ~d;
  endtask
endmodule
`default_nettype wire

// >>> sync_math_regs.vh
// Register map and timing constants of the dual-core sync and math unit.
// Assumes byte addresses on a 12-bit APB address, one 32-bit word per reg.
`ifndef SYNC_MATH_REGS_VH
`define SYNC_MATH_REGS_VH

// Core identity and shared pin registers (set/clr/xor aliases follow)
`define CORE_ID_OFS        12'h000
`define GPIO_OUT_OFS       12'h010
`define GPIO_OE_OFS        12'h020
// Mailbox and lock observation
`define MAILBOX_STATUS_OFS 12'h050
`define MAILBOX_WRITE_OFS  12'h054
`define MAILBOX_READ_OFS   12'h058
`define LOCK_STATE_VIEW_OFS 12'h05c
// Divider
`define UNSIGNED_NUM_OFS   12'h060
`define UNSIGNED_DEN_OFS   12'h064
`define SIGNED_NUM_OFS     12'h068
`define SIGNED_DEN_OFS     12'h06c
`define QUOTIENT_OFS       12'h070
`define REMAINDER_OFS      12'h074
`define DIVIDE_CSR_OFS     12'h078
// Interpolator
`define ACCUM_A_OFS        12'h080
`define ACCUM_B_OFS        12'h084
`define BASE_0_OFS         12'h088
`define BASE_1_OFS         12'h08c
`define BASE_2_OFS         12'h090
`define ADVANCE_0_OFS      12'h094
`define ADVANCE_1_OFS      12'h098
`define ADVANCE_2_OFS      12'h09c
`define VIEW_0_OFS         12'h0a0
`define VIEW_1_OFS         12'h0a4
`define VIEW_2_OFS         12'h0a8
`define ACCUM_A_ADD_OFS    12'h0b4
`define ACCUM_B_ADD_OFS    12'h0b8
// Lock flags occupy 0x100..0x17c; upper address bits select the window
`define LOCK_WINDOW        5'h02
// Mailbox status field positions
`define MB_HAS_DATA_BIT    0
`define MB_HAS_SPACE_BIT   1
`define MB_FULL_WR_ERR_BIT 2
`define MB_EMPTY_RD_ERR_BIT 3
// Divider status field positions
`define DIV_READY_BIT      0
`define DIV_DIRTY_BIT      1
// Divider run length in cycles, the reset value, and the quotient on a zero divisor
`define DIV_CYCLES         4'h8
`define ZERO_RESET         32'h00000000
`define DIV_ZERO_QUOTIENT  32'hffffffff

`endif

// >>> sync_math_unit.v
// Holds the whole unit: two APB slaves (one per core), locks, mailboxes,
// shared pin registers, and per-core divider and interpolator.
// Assumes both cores run on clk_i and each keeps to plain APB3 signalling.
`timescale 1ns/100ps
`default_nettype none
`include "sync_math_regs.vh"

module sync_math_unit #(
  parameter MB_DEPTH  = 8,
  parameter MB_AW     = 3,
  parameter PIN_WIDTH = 32
) (
  input  wire                 clk_i,
  input  wire                 rst_b_i,
  input  wire                 c0_psel_i,
  input  wire                 c0_penable_i,
  input  wire                 c0_pwrite_i,
  input  wire [11:0]          c0_paddr_i,
  input  wire [31:0]          c0_pwdata_i,
  output wire [31:0]          c0_prdata_o,
  output wire                 c0_pready_o,
  output wire                 c0_pslverr_o,
  input  wire                 c1_psel_i,
  input  wire                 c1_penable_i,
  input  wire                 c1_pwrite_i,
  input  wire [11:0]          c1_paddr_i,
  input  wire [31:0]          c1_pwdata_i,
  output wire [31:0]          c1_prdata_o,
  output wire                 c1_pready_o,
  output wire                 c1_pslverr_o,
  output wire [PIN_WIDTH-1:0] pin_out_o,
  output wire [PIN_WIDTH-1:0] pin_oe_o,
  output wire                 mbox_irq0_o,
  output wire                 mbox_irq1_o
);

  // Restoring division, four quotient bits per call
  function [63:0] div_step4;
    input [63:0] st;
    input [31:0] d;
    reg   [32:0] r;
    reg   [31:0] q;
    integer      i;
    begin
      r = {1'b0, st[63:32]};
      q = st[31:0];
      for (i = 0; i < 4; i = i + 1)
      begin
        r = {r[31:0], q[31]};
        q = {q[30:0], 1'b0};
        if (r >= {1'b0, d})
        begin
          r = r - {1'b0, d};
          q[0] = 1'b1;
        end
      end
      div_step4 = {r[31:0], q};
    end
  endfunction

  // Magnitude of an operand, two's complement only when signed
  function [31:0] magnitude;
    input [31:0] x;
    input        s;
    begin
      magnitude = (s && x[31]) ? (~x + 32'h1) : x;
    end
  endfunction

  // One pin register write: 0 plain, 1 set, 2 clear, 3 toggle
  function [PIN_WIDTH-1:0] pin_apply;
    input [PIN_WIDTH-1:0] cur;
    input [1:0]           kind;
    input [PIN_WIDTH-1:0] d;
    begin
      case (kind)
        2'h0:    pin_apply = d;
        2'h1:    pin_apply = cur | d;
        2'h2:    pin_apply = cur & ~d;
        default: pin_apply = cur ^ d;
      endcase
    end
  endfunction

  // Bundle the two APB ports so both cores share one description
  wire [1:0]  psel    = {c1_psel_i, c0_psel_i};
  wire [1:0]  penable = {c1_penable_i, c0_penable_i};
  wire [1:0]  pwrite  = {c1_pwrite_i, c0_pwrite_i};
  wire [11:0] paddr  [0:1];
  wire [31:0] pwdata [0:1];
  assign paddr[0]  = c0_paddr_i;
  assign paddr[1]  = c1_paddr_i;
  assign pwdata[0] = c0_pwdata_i;
  assign pwdata[1] = c1_pwdata_i;

  // Answer flops live in g_core; gathered here so each has one driver
  wire [1:0]  ack;
  wire [31:0] rdata [0:1];
  wire [1:0]  slverr;
  // Access acted on in the first access-phase cycle; one wait state
  wire [1:0]  ev  = psel & penable & ~ack;
  wire [1:0]  evw = ev & pwrite;
  wire [1:0]  evr = ev & ~pwrite;

  assign c0_pready_o  = ack[0];
  assign c1_pready_o  = ack[1];
  assign c0_prdata_o  = rdata[0];
  assign c1_prdata_o  = rdata[1];
  assign c0_pslverr_o = slverr[0];
  assign c1_pslverr_o = slverr[1];

  // Lock flags: core 0 handled first, so it wins a same-cycle claim
  reg  [31:0] lock_q;
  reg  [31:0] lock_d;
  reg  [1:0]  lock_got;
  integer     lc;
  always @*
  begin
    lock_d   = lock_q;
    lock_got = 2'b00;
    for (lc = 0; lc < 2; lc = lc + 1)
    begin
      if (ev[lc] && paddr[lc][11:7] == `LOCK_WINDOW
          && paddr[lc][1:0] == 2'b00)
      begin
        if (pwrite[lc])
          lock_d[paddr[lc][6:2]] = 1'b0;
        else
        begin
          lock_got[lc] = ~lock_d[paddr[lc][6:2]];
          lock_d[paddr[lc][6:2]] = 1'b1;
        end
      end
    end
  end

  // Shared pin registers: core 1's write applied on top of core 0's
  reg  [PIN_WIDTH-1:0] pin_out_q;
  reg  [PIN_WIDTH-1:0] pin_oe_q;
  reg  [PIN_WIDTH-1:0] pin_out_d;
  reg  [PIN_WIDTH-1:0] pin_oe_d;
  integer              pc;
  always @*
  begin
    pin_out_d = pin_out_q;
    pin_oe_d  = pin_oe_q;
    for (pc = 0; pc < 2; pc = pc + 1)
    begin
      if (evw[pc] && paddr[pc][11:4] == `GPIO_OUT_OFS >> 4
          && paddr[pc][1:0] == 2'b00)
        pin_out_d = pin_apply(pin_out_d, paddr[pc][3:2],
                              pwdata[pc][PIN_WIDTH-1:0]);
      if (evw[pc] && paddr[pc][11:4] == `GPIO_OE_OFS >> 4
          && paddr[pc][1:0] == 2'b00)
        pin_oe_d = pin_apply(pin_oe_d, paddr[pc][3:2],
                             pwdata[pc][PIN_WIDTH-1:0]);
    end
  end

  always @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      lock_q    <= `ZERO_RESET;
      pin_out_q <= {PIN_WIDTH{1'b0}};
      pin_oe_q  <= {PIN_WIDTH{1'b0}};
    end
    else
    begin
      lock_q    <= lock_d;
      pin_out_q <= pin_out_d;
      pin_oe_q  <= pin_oe_d;
    end
  end

  assign pin_out_o = pin_out_q;
  assign pin_oe_o  = pin_oe_q;

  // Mailbox queue q is written by core q and read by the other core
  wire [1:0]  mb_full;
  wire [1:0]  mb_empty;
  wire [1:0]  mb_wof;
  wire [1:0]  mb_roe;
  wire [31:0] mb_head [0:1];

  genvar q;
  generate
    for (q = 0; q < 2; q = q + 1)
    begin : g_mbox
      reg  [31:0]    mem [0:MB_DEPTH-1];
      reg  [MB_AW-1:0] wp_q;
      reg  [MB_AW-1:0] rp_q;
      reg  [MB_AW:0]   cnt_q;
      reg              wof_q;
      reg              roe_q;
      wire push = evw[q] && paddr[q] == `MAILBOX_WRITE_OFS;
      wire pop  = evr[1-q] && paddr[1-q] == `MAILBOX_READ_OFS;
      wire clr_w = evw[q] && paddr[q] == `MAILBOX_STATUS_OFS;
      wire clr_r = evw[1-q] && paddr[1-q] == `MAILBOX_STATUS_OFS;
      wire do_push = push && !mb_full[q];
      wire do_pop  = pop && !mb_empty[q];
      assign mb_full[q]  = cnt_q == MB_DEPTH;
      assign mb_empty[q] = cnt_q == {(MB_AW+1){1'b0}};
      assign mb_wof[q]   = wof_q;
      assign mb_roe[q]   = roe_q;
      assign mb_head[q]  = mem[rp_q];

      // Storage has no reset; only the pointers define the contents
      always @(posedge clk_i)
      begin
        if (do_push)
          mem[wp_q] <= pwdata[q];
      end

      // Error set wins over a clear in the same cycle
      always @(posedge clk_i)
      begin
        if (!rst_b_i)
        begin
          wp_q  <= {MB_AW{1'b0}};
          rp_q  <= {MB_AW{1'b0}};
          cnt_q <= {(MB_AW+1){1'b0}};
          wof_q <= 1'b0;
          roe_q <= 1'b0;
        end
        else
        begin
          if (do_push)
            wp_q <= wp_q + 1'b1;
          if (do_pop)
            rp_q <= rp_q + 1'b1;
          if (do_push && !do_pop)
            cnt_q <= cnt_q + 1'b1;
          else if (do_pop && !do_push)
            cnt_q <= cnt_q - 1'b1;
          if (push && mb_full[q])
            wof_q <= 1'b1;
          else if (clr_w)
            wof_q <= 1'b0;
          if (pop && mb_empty[q])
            roe_q <= 1'b1;
          else if (clr_r)
            roe_q <= 1'b0;
        end
      end
    end
  endgenerate

  // Core c sees incoming queue 1-c and outgoing queue c
  wire [3:0] mb_stat [0:1];
  assign mb_stat[0] = {mb_roe[1], mb_wof[0], ~mb_full[0], ~mb_empty[1]};
  assign mb_stat[1] = {mb_roe[0], mb_wof[1], ~mb_full[1], ~mb_empty[0]};
  assign mbox_irq0_o = |{mb_stat[0][3:2], mb_stat[0][0]};
  assign mbox_irq1_o = |{mb_stat[1][3:2], mb_stat[1][0]};

  // Per-core divider, interpolator and register read port
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1)
    begin : g_core
      wire [11:0] a  = paddr[c];
      wire [31:0] wd = pwdata[c];
      reg  [31:0] num_q;
      reg  [31:0] den_q;
      reg         sgn_q;
      reg  [3:0]  cnt_q;
      reg  [63:0] wrk_q;
      reg  [31:0] dvs_q;
      reg         qneg_q;
      reg         rneg_q;
      reg         dz_q;
      reg  [31:0] quot_q;
      reg  [31:0] rem_q;
      reg         dirty_q;
      wire wr_num = evw[c] && (a == `UNSIGNED_NUM_OFS
                               || a == `SIGNED_NUM_OFS);
      wire wr_den = evw[c] && (a == `UNSIGNED_DEN_OFS
                               || a == `SIGNED_DEN_OFS);
      wire wr_res = evw[c] && (a == `QUOTIENT_OFS
                               || a == `REMAINDER_OFS);
      wire [31:0] n_use = wr_num ? wd : num_q;
      wire [31:0] d_use = wr_den ? wd : den_q;
      wire        s_use = (wr_num || wr_den)
                          ? (a == `SIGNED_NUM_OFS || a == `SIGNED_DEN_OFS)
                          : sgn_q;
      wire [63:0] nxt   = div_step4(wrk_q, dvs_q);
      wire        ready = cnt_q == 4'h0;

      // Divider: operand writes restart, result writes cancel
      always @(posedge clk_i)
      begin
        if (!rst_b_i)
        begin
          num_q   <= `ZERO_RESET;
          den_q   <= `ZERO_RESET;
          sgn_q   <= 1'b0;
          cnt_q   <= 4'h0;
          wrk_q   <= 64'h0;
          dvs_q   <= `ZERO_RESET;
          qneg_q  <= 1'b0;
          rneg_q  <= 1'b0;
          dz_q    <= 1'b0;
          quot_q  <= `ZERO_RESET;
          rem_q   <= `ZERO_RESET;
          dirty_q <= 1'b0;
        end
        else if (wr_num || wr_den)
        begin
          num_q   <= n_use;
          den_q   <= d_use;
          sgn_q   <= s_use;
          cnt_q   <= `DIV_CYCLES;
          wrk_q   <= {32'h0, magnitude(n_use, s_use)};
          dvs_q   <= magnitude(d_use, s_use);
          qneg_q  <= s_use && (n_use[31] ^ d_use[31]);
          rneg_q  <= s_use && n_use[31];
          dz_q    <= d_use == 32'h0;
          dirty_q <= 1'b1;
        end
        else if (wr_res)
        begin
          cnt_q   <= 4'h0;
          dirty_q <= 1'b1;
          if (a == `QUOTIENT_OFS)
            quot_q <= wd;
          else
            rem_q  <= wd;
        end
        else
        begin
          if (evr[c] && a == `QUOTIENT_OFS)
            dirty_q <= 1'b0;
          if (!ready)
          begin
            wrk_q <= nxt;
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h1)
            begin
              // Zero divisor keeps the same timing and raises nothing
              quot_q <= dz_q ? `DIV_ZERO_QUOTIENT
                        : (qneg_q ? ~nxt[31:0] + 32'h1 : nxt[31:0]);
              rem_q  <= rneg_q ? ~nxt[63:32] + 32'h1 : nxt[63:32];
            end
          end
        end
      end

      // Interpolator with adder lanes: lane value is base plus accumulator, lane 2 adds both
      reg  [31:0] acc_a_q;
      reg  [31:0] acc_b_q;
      reg  [31:0] base0_q;
      reg  [31:0] base1_q;
      reg  [31:0] base2_q;
      wire [31:0] res0 = base0_q + acc_a_q;
      wire [31:0] res1 = base1_q + acc_b_q;
      wire [31:0] res2 = base2_q + acc_a_q + acc_b_q;
      wire        advance = evr[c] && (a == `ADVANCE_0_OFS
                          || a == `ADVANCE_1_OFS || a == `ADVANCE_2_OFS);

      always @(posedge clk_i)
      begin
        if (!rst_b_i)
        begin
          acc_a_q <= `ZERO_RESET;
          acc_b_q <= `ZERO_RESET;
          base0_q <= `ZERO_RESET;
          base1_q <= `ZERO_RESET;
          base2_q <= `ZERO_RESET;
        end
        else if (advance)
        begin
          acc_a_q <= res0;
          acc_b_q <= res1;
        end
        else if (evw[c])
        begin
          case (a)
            `ACCUM_A_OFS:     acc_a_q <= wd;
            `ACCUM_B_OFS:     acc_b_q <= wd;
            `ACCUM_A_ADD_OFS: acc_a_q <= acc_a_q + wd;
            `ACCUM_B_ADD_OFS: acc_b_q <= acc_b_q + wd;
            `BASE_0_OFS:      base0_q <= wd;
            `BASE_1_OFS:      base1_q <= wd;
            `BASE_2_OFS:      base2_q <= wd;
            default:          acc_a_q <= acc_a_q;
          endcase
        end
      end

      // Read decode; unmapped addresses read zero with an error answer
      reg  [31:0] rd;
      reg         hit;
      always @*
      begin
        rd  = 32'h0;
        hit = 1'b1;
        case (a)
          `CORE_ID_OFS:         rd = c;
          `GPIO_OUT_OFS:        rd = pin_out_q;
          `GPIO_OE_OFS:         rd = pin_oe_q;
          `MAILBOX_STATUS_OFS:  rd = {28'h0, mb_stat[c]};
          `MAILBOX_WRITE_OFS:   rd = 32'h0;
          `MAILBOX_READ_OFS:    rd = mb_empty[1-c] ? 32'h0 : mb_head[1-c];
          `LOCK_STATE_VIEW_OFS: rd = lock_q;
          `UNSIGNED_NUM_OFS:    rd = num_q;
          `SIGNED_NUM_OFS:      rd = num_q;
          `UNSIGNED_DEN_OFS:    rd = den_q;
          `SIGNED_DEN_OFS:      rd = den_q;
          `QUOTIENT_OFS:        rd = quot_q;
          `REMAINDER_OFS:       rd = rem_q;
          `DIVIDE_CSR_OFS:      rd = {30'h0, dirty_q, ready};
          `ACCUM_A_OFS:         rd = acc_a_q;
          `ACCUM_B_OFS:         rd = acc_b_q;
          `BASE_0_OFS:          rd = base0_q;
          `BASE_1_OFS:          rd = base1_q;
          `BASE_2_OFS:          rd = base2_q;
          `VIEW_0_OFS:          rd = res0;
          `VIEW_1_OFS:          rd = res1;
          `VIEW_2_OFS:          rd = res2;
          `ADVANCE_0_OFS:       rd = res0;
          `ADVANCE_1_OFS:       rd = res1;
          `ADVANCE_2_OFS:       rd = res2;
          `ACCUM_A_ADD_OFS:     rd = acc_a_q;
          `ACCUM_B_ADD_OFS:     rd = acc_b_q;
          default:
          begin
            // Pin aliases and lock window are mapped; all else errors
            hit = (a[11:4] == `GPIO_OUT_OFS >> 4
                   || a[11:4] == `GPIO_OE_OFS >> 4
                   || a[11:7] == `LOCK_WINDOW) && a[1:0] == 2'b00;
            rd  = {31'h0, lock_got[c]};
          end
        endcase
        if (!hit)
          rd = 32'h0;
      end

      reg         ack_q;
      reg  [31:0] rdata_q;
      reg         slverr_q;
      assign ack[c]    = ack_q;
      assign rdata[c]  = rdata_q;
      assign slverr[c] = slverr_q;

      // Answer registered one cycle after the access phase opens
      always @(posedge clk_i)
      begin
        if (!rst_b_i)
        begin
          ack_q    <= 1'b0;
          rdata_q  <= `ZERO_RESET;
          slverr_q <= 1'b0;
        end
        else
        begin
          ack_q <= ev[c];
          if (ev[c])
          begin
            rdata_q  <= pwrite[c] ? 32'h0 : rd;
            slverr_q <= ~hit;
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// >>> sync_math_unit_assertions.sv
// Checker for sync_math_unit: answer pulse, lock tie, mailbox irq,
// divider ready and dirty flag, shared pin write order.
// Assumes core 0 drives the divider; sees only the top module's ports.
`timescale 1ns/100ps
`default_nettype none
`include "sync_math_regs.vh"
module sync_math_unit_assertions #(
  parameter PIN_WIDTH = 32
) (
  input wire logic                 clk_i,
  input wire logic                 rst_b_i,
  input wire logic                 c0_psel_i,
  input wire logic                 c0_penable_i,
  input wire logic                 c0_pwrite_i,
  input wire logic [11:0]          c0_paddr_i,
  input wire logic [31:0]          c0_prdata_o,
  input wire logic                 c0_pready_o,
  input wire logic                 c1_psel_i,
  input wire logic                 c1_penable_i,
  input wire logic                 c1_pwrite_i,
  input wire logic [11:0]          c1_paddr_i,
  input wire logic [31:0]          c1_pwdata_i,
  input wire logic [31:0]          c1_prdata_o,
  input wire logic                 c1_pready_o,
  input wire logic [PIN_WIDTH-1:0] pin_out_o,
  input wire logic                 mbox_irq0_o,
  input wire logic                 mbox_irq1_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [3:0] age_q;
  logic       dirty_q;
  // Accesses are taken at the first enable edge, before pready
  wire t0 = c0_psel_i & c0_penable_i & ~c0_pready_o;
  wire t1 = c1_psel_i & c1_penable_i & ~c1_pready_o;
  wire rd0 = t0 & ~c0_pwrite_i;
  wire wr0 = t0 & c0_pwrite_i;
  wire op0 = wr0 & (c0_paddr_i[11:4] == 8'h06);
  wire res0 = wr0 & (c0_paddr_i[11:3] == 9'h00e);
  wire csr0 = rd0 & (c0_paddr_i == `DIVIDE_CSR_OFS);
  wire tie = t0 & t1 & ~c0_pwrite_i & ~c1_pwrite_i &
             (c0_paddr_i[11:7] == `LOCK_WINDOW) & (c0_paddr_i == c1_paddr_i);
  // The other core is kept out so it cannot move the status meanwhile
  wire st0 = rd0 & ~t1 & (c0_paddr_i == `MAILBOX_STATUS_OFS);
  wire st1 = t1 & ~c1_pwrite_i & ~t0 & (c1_paddr_i == `MAILBOX_STATUS_OFS);
  wire pw1 = t1 & c1_pwrite_i & (c1_paddr_i == `GPIO_OUT_OFS);
  // Cycles since the last operand write; a result write parks it at 0
  always_ff @(posedge clk_i)
    if (!rst_b_i)
      age_q <= 4'h0;
    else if (op0)
      age_q <= 4'h1;
    else if (res0)
      age_q <= 4'h0;
    else if (age_q != 4'h0 && age_q != 4'hf)
      age_q <= age_q + 4'h1;
  // Dirty follows register writes until the quotient is read
  always_ff @(posedge clk_i)
    if (!rst_b_i)
      dirty_q <= 1'b0;
    else if (op0 | res0)
      dirty_q <= 1'b1;
    else if (rd0 && c0_paddr_i == `QUOTIENT_OFS)
      dirty_q <= 1'b0;
  rdy_pulse_a: assert property (t0 |=> c0_pready_o ##1 !c0_pready_o)
    else $error("answer is not one pulse");
  lock_tie_a: assert property (tie |=> c1_prdata_o == 32'h0)
    else $error("core 1 won a tied claim");
  irq0_or_a: assert property (st0 |=> mbox_irq0_o ==
    |{c0_prdata_o[3:2], c0_prdata_o[0]}) else $error("irq 0 mismatch");
  irq1_or_a: assert property (st1 |=> mbox_irq1_o ==
    |{c1_prdata_o[3:2], c1_prdata_o[0]}) else $error("irq 1 mismatch");
  div_busy_a: assert property (csr0 && age_q != 4'h0 && age_q < 4'h9
    |=> !c0_prdata_o[0]) else $error("divider ready too early");
  div_ready_a: assert property (csr0 && age_q >= 4'h9
    |=> c0_prdata_o[0]) else $error("divider not ready in time");
  div_dirty_a: assert property (csr0
    |=> c0_prdata_o[1] == $past(dirty_q)) else $error("dirty flag wrong");
  pin_order_a: assert property (pw1
    |=> pin_out_o == $past(c1_pwdata_i)) else $error("core 1 not last");
  cover property (tie);
  cover property (csr0 && age_q == 4'h4);
  cover property (pw1 && t0);
endmodule
bind sync_math_unit sync_math_unit_assertions #(.PIN_WIDTH(PIN_WIDTH)) chk_u (
  .clk_i, .rst_b_i, .c0_psel_i, .c0_penable_i, .c0_pwrite_i, .c0_paddr_i,
  .c0_prdata_o, .c0_pready_o, .c1_psel_i, .c1_penable_i, .c1_pwrite_i,
  .c1_paddr_i, .c1_pwdata_i, .c1_prdata_o, .c1_pready_o, .pin_out_o,
  .mbox_irq0_o, .mbox_irq1_o);
`default_nettype wire

// >>> tb_top.sv
// Testbench for sync_math_unit: two core models on the APB ports.
// Assumes the register map header and a 125 MHz clock.
`timescale 1ns/100ps
`default_nettype none
`include "sync_math_regs.vh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic        clk_i;
  logic        rst_b_i;
  wire  [1:0]  sel, ena, wrt, rdy, err;
  wire  [11:0] adr [2];
  wire  [31:0] wdt [2];
  wire  [31:0] rdt [2];
  wire  [31:0] pin_out, pin_oe;
  wire         irq0, irq1;
  int          error_cnt = 0;
  int          total_checks = 0;
  int          n;
  logic [11:0] a;
  sync_math_unit dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .c0_psel_i(sel[0]), .c0_penable_i(ena[0]), .c0_pwrite_i(wrt[0]),
    .c0_paddr_i(adr[0]), .c0_pwdata_i(wdt[0]), .c0_prdata_o(rdt[0]),
    .c0_pready_o(rdy[0]), .c0_pslverr_o(err[0]),
    .c1_psel_i(sel[1]), .c1_penable_i(ena[1]), .c1_pwrite_i(wrt[1]),
    .c1_paddr_i(adr[1]), .c1_pwdata_i(wdt[1]), .c1_prdata_o(rdt[1]),
    .c1_pready_o(rdy[1]), .c1_pslverr_o(err[1]), .pin_out_o(pin_out),
    .pin_oe_o(pin_oe), .mbox_irq0_o(irq0), .mbox_irq1_o(irq1));
  core_model c0_u (.clk_i(clk_i), .psel_o(sel[0]), .penable_o(ena[0]),
    .pwrite_o(wrt[0]), .paddr_o(adr[0]), .pwdata_o(wdt[0]),
    .prdata_i(rdt[0]), .pready_i(rdy[0]), .pslverr_i(err[0]));
  core_model c1_u (.clk_i(clk_i), .psel_o(sel[1]), .penable_o(ena[1]),
    .pwrite_o(wrt[1]), .paddr_o(adr[1]), .pwdata_o(wdt[1]),
    .prdata_i(rdt[1]), .pready_i(rdy[1]), .pslverr_i(err[1]));
  // Clock, 8 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic x(input int c, input logic w, input logic [11:0] ad,
                   input logic [31:0] d, output logic [31:0] q);
    if (c == 0)
      c0_u.xfer(w, ad, d, q);
    else
      c1_u.xfer(w, ad, d, q);
  endtask
  task automatic wr(input int c, input logic [11:0] ad, input logic [31:0] d);
    logic [31:0] q;
    x(c, 1'b1, ad, d, q);
  endtask
  task automatic rc(input int c, input logic [11:0] ad,
                    input logic [31:0] e, input string nm);
    logic [31:0] q;
    x(c, 1'b0, ad, 32'h0, q);
    `CHK(nm, e, q)
  endtask
  // Both cores write in the same cycle
  task automatic both(input logic [11:0] a0, input logic [31:0] d0,
                      input logic [11:0] a1, input logic [31:0] d1);
    fork
      wr(0, a0, d0);
      wr(1, a1, d1);
    join
  endtask
  // Operands in the given order, then results after the run length
  task automatic div(input logic [11:0] da, input logic [31:0] dv,
    input logic [11:0] na, input logic [31:0] nv, input logic [31:0] eq, er);
    wr(0, da, dv);
    wr(0, na, nv);
    repeat (8) @(posedge clk_i);
    rc(0, `REMAINDER_OFS, er, "remainder");
    rc(0, `QUOTIENT_OFS, eq, "quotient");
  endtask
  task timeout();
    error_cnt++;
    results();
  endtask
  task results();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    rst_b_i = 1'b0;
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rc(0, `DIVIDE_CSR_OFS, 32'h1, "divide_ctrl_status");
    rc(0, 12'h040, 32'h0, "unmapped");
    `CHK("slverr", 1'b1, c0_u.last_err)
    for (n = 0; n < 32; n += 31)
    begin
      a = 12'h100 + 12'(4 * n);
      rc(0, a, 32'h1, "claim");
      rc(1, a, 32'h0, "held");
      rc(0, `LOCK_STATE_VIEW_OFS, 32'h1 << n, "lock view");
      wr(1, a, 32'h0);
      rc(1, a, 32'h1, "reclaim");
      wr(0, a, 32'h5a);
    end
    fork
      rc(0, 12'h114, 32'h1, "tie 0");
      rc(1, 12'h114, 32'h0, "tie 1");
    join
    $display("test locks done");
    rc(0, `MAILBOX_STATUS_OFS, 32'h2, "mb empty");
    for (n = 1; n <= 9; n++)
      wr(0, `MAILBOX_WRITE_OFS, 32'(n));
    rc(0, `MAILBOX_STATUS_OFS, 32'h4, "mb full");
    rc(1, `MAILBOX_STATUS_OFS, 32'h3, "mb data");
    for (n = 1; n <= 8; n++)
      rc(1, `MAILBOX_READ_OFS, 32'(n), "mb pop");
    rc(1, `MAILBOX_READ_OFS, 32'h0, "mb empty pop");
    rc(1, `MAILBOX_STATUS_OFS, 32'ha, "mb error");
    `CHK("irq 1", 1'b1, irq1)
    wr(1, `MAILBOX_STATUS_OFS, 32'h0);
    `CHK("irq 1 clear", 1'b0, irq1)
    wr(0, `MAILBOX_STATUS_OFS, 32'h0);
    wr(1, `MAILBOX_WRITE_OFS, 32'hc0de1);
    rc(0, `MAILBOX_STATUS_OFS, 32'h3, "mb back");
    `CHK("irq 0", 1'b1, irq0)
    rc(0, `MAILBOX_READ_OFS, 32'hc0de1, "mb back pop");
    $display("test mailbox done");
    wr(0, `UNSIGNED_NUM_OFS, 32'd1);
    rc(0, `DIVIDE_CSR_OFS, 32'h2, "div busy");
    div(`UNSIGNED_DEN_OFS, 7, `UNSIGNED_NUM_OFS, 100, 14, 2);
    div(`SIGNED_DEN_OFS, 7, `SIGNED_NUM_OFS, -100, -14, -2);
    div(`UNSIGNED_DEN_OFS, 7, `UNSIGNED_NUM_OFS, -100, 32'h24924916, 2);
    div(`UNSIGNED_DEN_OFS, 0, `UNSIGNED_NUM_OFS, 100, -1, 100);
    div(`UNSIGNED_NUM_OFS, 99, `UNSIGNED_NUM_OFS, 30, -1, 30);
    rc(0, `DIVIDE_CSR_OFS, 32'h1, "div clean");
    wr(0, `UNSIGNED_NUM_OFS, 32'd60);
    wr(0, `QUOTIENT_OFS, 32'h5);
    repeat (8) @(posedge clk_i);
    rc(0, `QUOTIENT_OFS, 32'h5, "restored");
    $display("test divider done");
    wr(0, `ACCUM_A_OFS, 32'd10);
    wr(0, `BASE_0_OFS, 32'd9);
    rc(0, `VIEW_0_OFS, 32'd19, "view");
    rc(0, `VIEW_0_OFS, 32'd19, "view again");
    rc(0, `ADVANCE_0_OFS, 32'd19, "advance");
    rc(0, `ACCUM_A_OFS, 32'd19, "reloaded");
    wr(0, `ACCUM_A_ADD_OFS, 32'd5);
    wr(0, `ACCUM_B_ADD_OFS, 32'd3);
    rc(0, `VIEW_2_OFS, 32'd27, "view 2");
    $display("test interpolator done");
    both(`GPIO_OUT_OFS, 32'hf0, `GPIO_OUT_OFS, 32'h0f);
    `CHK("pin order", 32'h0f, pin_out)
    both(12'h014, 32'h100, 12'h01c, 32'h100);
    `CHK("set then xor", 32'h0f, pin_out)
    both(`GPIO_OE_OFS, 32'h5, 12'h028, 32'h1);
    `CHK("oe order", 32'h4, pin_oe)
    $display("test pins done");
    results();
  end
endmodule
`default_nettype wire
